// file: design/psw_ctrl.sv
// Power on/off control from a slider or push-button power key, with host hold.
// Assumes the key pin is pulled up on the board and the strap is stable.
// Functional notes
// - Strap low selects slider, high push-button.
// - Push-button debounced by 32 ms timer.
// - Each qualified press toggles power state.
// - Same qualification time for on and off.
// - Slider mode: key grounded powers up.
// - Slider mode: power follows key level.
// - Hold falling edge after armed powers down.
`timescale 1ns/1ps
`default_nettype none
module psw_ctrl #(
    parameter int unsigned QUAL_CYCLES = psw_pkg::QUAL_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Board pins
    input wire logic power_key_i,
    input wire logic switch_type_select_i,
    input wire logic power_hold_i,
    // Power and mode outputs
    output logic system_power_on_o,
    output logic regulated_supply_output_o,
    output logic push_button_mode_o
);
    logic rst_meta_q, rst_sync_q;
    wire rst_n = rst_sync_q;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    logic key_s, hold_s;
    // Key synchronised; both stages sit inside psw_sync
    psw_sync #(.RST_VAL(1'b1)) u_key_sync (
        .clk_i(ref_clk_i), .rst_n_i(rst_n), .d_i(power_key_i), .q_o(key_s));
    psw_sync #(.RST_VAL(1'b0)) u_hold_sync (
        .clk_i(ref_clk_i), .rst_n_i(rst_n), .d_i(power_hold_i), .q_o(hold_s));

    // Strap caught once after reset release; later changes ignored
    logic strap_done_q, pb_mode_q;
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            strap_done_q <= 1'b0;
            pb_mode_q <= 1'b0;
        end else if (!strap_done_q) begin
            strap_done_q <= 1'b1;
            pb_mode_q <= switch_type_select_i;
        end
    end

    psw_pkg::psw_state_t state_q, state_d;
    logic [psw_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic pwr_q, pwr_d;
    logic key_prev_q, hold_prev_q, armed_q;

    wire key_pressed = ~key_s;
    wire key_changed = key_s != key_prev_q;
    // Cut on purpose: the full count always fits the counter width
    wire [psw_pkg::CNT_W-1:0] qual_last = psw_pkg::CNT_W'(QUAL_CYCLES - 1);
    wire qual_done = cnt_q == qual_last;
    wire hold_fall = hold_prev_q & ~hold_s;
    wire hold_off = armed_q & hold_fall & pwr_q;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        pwr_d = pwr_q;
        if (!strap_done_q) begin
            state_d = psw_pkg::PSW_IDLE;
        end else if (!pb_mode_q) begin
            // Slider: level decides directly, no debounce
            pwr_d = key_pressed;
            state_d = psw_pkg::PSW_IDLE;
        end else begin
            unique case (state_q)
                psw_pkg::PSW_IDLE: begin
                    cnt_d = '0;
                    if (key_pressed) begin
                        state_d = psw_pkg::PSW_QUAL;
                    end
                end
                psw_pkg::PSW_QUAL: begin
                    if (!key_pressed) begin
                        state_d = psw_pkg::PSW_IDLE;
                    end else if (qual_done) begin
                        pwr_d = ~pwr_q;
                        state_d = psw_pkg::PSW_WAIT;
                    end else begin
                        cnt_d = cnt_q + 1'b1;
                    end
                end
                psw_pkg::PSW_WAIT: begin
                    // One toggle per press: wait for release
                    cnt_d = '0;
                    if (!key_pressed) begin
                        state_d = psw_pkg::PSW_IDLE;
                    end
                end
                default: state_d = psw_pkg::PSW_IDLE;
            endcase
            if (key_changed && state_q == psw_pkg::PSW_QUAL) begin
                cnt_d = '0;
            end
        end
        if (hold_off) begin
            pwr_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= psw_pkg::PSW_IDLE;
            cnt_q <= '0;
            pwr_q <= psw_pkg::PWR_RST;
            key_prev_q <= 1'b1;
            hold_prev_q <= 1'b0;
            armed_q <= 1'b0;
            system_power_on_o <= 1'b0;
            regulated_supply_output_o <= 1'b0;
            push_button_mode_o <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            pwr_q <= pwr_d;
            key_prev_q <= key_s;
            hold_prev_q <= hold_s;
            // Hold only counts once raised while powered; cleared at power-off
            armed_q <= pwr_d & (armed_q | hold_s);
            system_power_on_o <= pwr_d;
            regulated_supply_output_o <= pwr_d;
            push_button_mode_o <= pb_mode_q;
        end
    end

    // Assertions
    sequence s_press_held;
        state_q == psw_pkg::PSW_QUAL && key_pressed && qual_done;
    endsequence

    sequence s_press_start;
        pb_mode_q && state_q == psw_pkg::PSW_IDLE && key_pressed;
    endsequence

    sequence s_slider_ground;
        strap_done_q && !pb_mode_q && key_pressed && !hold_off;
    endsequence

    a_pb_toggle: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (s_press_held and (pb_mode_q && !hold_off)) |=> pwr_q != $past(pwr_q))
        else $error("qualified press did not toggle power");

    a_short_ignored: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        pb_mode_q && state_q == psw_pkg::PSW_QUAL && !qual_done && !hold_off
        |=> pwr_q == $past(pwr_q))
        else $error("power changed before qualification");

    a_slider_follow: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        strap_done_q && !pb_mode_q && !hold_off |=> pwr_q == $past(key_pressed))
        else $error("slider power does not follow key");

    a_hold_off: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        hold_off |=> !pwr_q && !system_power_on_o && !regulated_supply_output_o)
        else $error("hold fall did not power down");

    a_cnt_restart: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        pb_mode_q && state_q == psw_pkg::PSW_QUAL && key_changed |=> cnt_q == '0)
        else $error("counter not restarted on key change");

    a_mode_latch: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        strap_done_q |=> pb_mode_q == $past(pb_mode_q))
        else $error("mode changed after strap capture");

    a_one_per_press: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        state_q == psw_pkg::PSW_WAIT && key_pressed && !hold_off
        |=> pwr_q == $past(pwr_q))
        else $error("second toggle within one press");

    a_ldo_match: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        regulated_supply_output_o == system_power_on_o)
        else $error("supply output differs from power state");

    a_qual_enter: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        s_press_start |=> state_q == psw_pkg::PSW_QUAL && cnt_q == '0)
        else $error("press did not start a fresh qualification");

    a_slider_on: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        s_slider_ground |=> pwr_q && system_power_on_o && regulated_supply_output_o)
        else $error("grounded slider did not power up");

    a_strap_capture: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        !strap_done_q |=> pb_mode_q == $past(switch_type_select_i))
        else $error("strap level not captured as mode");

    a_cnt_bound: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        state_q == psw_pkg::PSW_QUAL |-> cnt_q <= qual_last)
        else $error("qualification count ran past its end");

    a_idle_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        pb_mode_q && state_q == psw_pkg::PSW_IDLE |=> cnt_q == '0)
        else $error("counter not cleared while idle");

    a_release_rearm: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        pb_mode_q && state_q == psw_pkg::PSW_WAIT && !key_pressed |=> state_q == psw_pkg::PSW_IDLE)
        else $error("release did not rearm the key");

    a_out_match: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        system_power_on_o == pwr_q)
        else $error("power output differs from power state");

    a_armed_pwr: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        armed_q |-> pwr_q)
        else $error("hold armed while powered down");
endmodule // psw_ctrl
`default_nettype wire

// file: design/psw_pkg.sv
// Constants for the power key on/off control block.
// Assumes a single 200 MHz clock.
package psw_pkg;
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned QUAL_TIME_MS = 32;
    // Qualification count in clock cycles (least time, exact here)
    localparam int unsigned QUAL_CYCLES = QUAL_TIME_MS * 1000 * CLK_MHZ;
    localparam int unsigned CNT_W = 24;
    localparam logic [1:0] SYNC_RST = 2'h3;
    localparam logic PWR_RST = 1'b0;

    typedef enum logic [1:0] {
        PSW_IDLE = 2'h0,
        PSW_QUAL = 2'h1,
        PSW_WAIT = 2'h3
    } psw_state_t;
endpackage : psw_pkg

// file: design/psw_sync.sv
// Two-flop synchroniser for one level.
// Assumes the caller supplies the released reset.
`timescale 1ns/1ps
`default_nettype none
module psw_sync #(
    parameter logic RST_VAL = 1'b1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Level
    input wire logic d_i,
    output logic q_o
);
    logic meta_q;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= RST_VAL;
            q_o <= RST_VAL;
        end else begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule // psw_sync
`default_nettype wire

// file: dv/psw_board.sv
// Board model: pulled-up power key pin and host hold line.
// Assumes the bench commands the presses and the host stop.
`timescale 1ns/1ps
`default_nettype none
module psw_board (
    // Clock and commands
    input wire logic ref_clk_i,
    input wire logic press_i,
    input wire logic stop_i,
    input wire logic sys_on_i,
    // Pins
    output logic power_key_o,
    output var logic power_hold_o = 1'b0
);
    // Open key reads high through the pull-up
    assign power_key_o = press_i ? 1'b0 : 1'b1;
    // Host arms hold once powered, drops it when the bench raises stop
    always @(posedge ref_clk_i) begin
        if (stop_i || sys_on_i) begin
            power_hold_o <= #1 !stop_i;
        end
    end
endmodule // psw_board
`default_nettype wire

// file: dv/power_switch_on_off_control_test.sv
// Bench for the power key on/off control block.
// Assumes the board model drives the key and hold pins.
`timescale 1ns/1ps
`default_nettype none
module power_switch_on_off_control_test;
    // Short count keeps the run brief
    localparam int unsigned QC = 20;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic strap = 1'b0;
    logic press = 1'b0;
    logic stop = 1'b0;
    wire key, hold, pwr, ldo, pbm;
    int error_cnt = 0;
    int samples_checked = 0;
    always #2.5 ref_clk_i = ~ref_clk_i;
    psw_ctrl #(.QUAL_CYCLES(QC)) u_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .power_key_i(key), .switch_type_select_i(strap), .power_hold_i(hold),
        .system_power_on_o(pwr), .regulated_supply_output_o(ldo), .push_button_mode_o(pbm));
    psw_board u_board (.ref_clk_i(ref_clk_i), .press_i(press), .stop_i(stop),
        .sys_on_i(pwr), .power_key_o(key), .power_hold_o(hold));
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic chk(input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic wait_pwr(input logic exp, input int lim);
        for (int i = 0; i < lim && pwr !== exp; i++) cyc(1);
        chk(exp, pwr);
        chk(exp, ldo);
        if (pwr !== exp) give_verdict();
    endtask
    task automatic do_reset(input logic sel);
        rst_n_i = 1'b0;
        strap = sel;
        cyc(6);
        rst_n_i = 1'b1;
        cyc(6);
        chk(sel, pbm);
    endtask
    task automatic t_slider;
        do_reset(1'b0);
        wait_pwr(1'b0, 1);
        press = 1'b1;
        wait_pwr(1'b1, 8);
        press = 1'b0;
        wait_pwr(1'b0, 8);
    endtask
    task automatic t_button;
        do_reset(1'b1);
        press = 1'b1;
        cyc(QC / 2);
        press = 1'b0;
        cyc(QC + 8);
        chk(1'b0, pwr);
        press = 1'b1;
        cyc(QC - 5);
        press = 1'b0;
        cyc(1);
        press = 1'b1;
        cyc(QC - 5);
        press = 1'b0;
        cyc(QC + 8);
        chk(1'b0, pwr);
        press = 1'b1;
        cyc(QC - 2);
        chk(1'b0, pwr);
        wait_pwr(1'b1, 16);
        cyc(3 * QC);
        chk(1'b1, pwr);
        press = 1'b0;
        cyc(6);
        press = 1'b1;
        cyc(QC - 2);
        chk(1'b1, pwr);
        wait_pwr(1'b0, 16);
        press = 1'b0;
    endtask
    task automatic t_hold;
        cyc(6);
        press = 1'b1;
        wait_pwr(1'b1, QC + 10);
        press = 1'b0;
        cyc(8);
        stop = 1'b1;
        wait_pwr(1'b0, 8);
        stop = 1'b0;
    endtask
    task automatic give_verdict;
        $display("checks=%0d errors=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        t_slider();
        t_button();
        t_hold();
        give_verdict();
    end
endmodule // power_switch_on_off_control_test
`default_nettype wire
